//--- azc_pkg.sv
package azc_pkg;
    // =========================================================
    // register map (byte addresses)
    localparam logic [7:0] STATUS_ADDR = 8'h0C;
    localparam logic [7:0] INT_EN_ADDR = 8'h10;
    localparam logic [7:0] INT_CLR_ADDR = 8'h14;
    localparam logic [7:0] INT_STAT_ADDR = 8'h18;
    // =========================================================
    // field positions in the status word
    localparam int RX_LEVEL_LSB = 24;
    localparam int RX_LEVEL_MSB = 27;
    localparam int LZC_BIT = 23;
    localparam int RZC_BIT = 22;
    // =========================================================
    // sizes and reset values
    localparam int SAMPLE_W = 16;
    localparam int LEVEL_W = 4;
    localparam logic [LEVEL_W-1:0] LEVEL_MAX = 4'h8;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    // interrupt bit positions: 0 left crossing, 1 right crossing
    localparam int IRQ_L = 0;
    localparam int IRQ_R = 1;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } azc_bus_req_t;

    typedef struct packed {
        logic valid;
        logic [SAMPLE_W-1:0] data;
    } azc_sample_t;
endpackage

//--- azc_zc_det.sv
`timescale 1ns/1ps
// =========================================================
// zero crossing detector for one channel
module azc_zc_det #(
    parameter int W = 16
) (
    input wire logic ref_clk, // clock
    input wire logic reset, // async reset, high
    input wire logic smp_valid, // new sample strobe
    input wire logic [W-1:0] smp_data, // sample word
    output logic zc_pulse // one-cycle crossing pulse
);
    logic sign_q, sign_d;
    logic cross_q, cross_d;

    // sign change against previous sample, or an all-zero sample
    always_comb
    begin
        sign_d = sign_q;
        cross_d = 1'b0;
        if (smp_valid)
        begin
            sign_d = smp_data[W-1];
            cross_d = (smp_data[W-1] != sign_q) || (smp_data == '0); // RULE2 RULE6
        end
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            sign_q <= 1'b0;
            cross_q <= 1'b0;
        end
        else
        begin
            sign_q <= sign_d;
            cross_q <= cross_d;
        end
    end

    assign zc_pulse = cross_q;
endmodule

//--- azc_status.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: bits 27:24 report receive FIFO word count
// RULE2: left crossing: sign change or zero sample
// RULE3: left flag bit 23 sticky until write-1
// RULE4: right flag bit 22 set on crossing
// RULE5: right flag cleared by write-1 only
// RULE6: right channel uses same crossing test
module azc_status #(
    parameter int SAMPLE_W = azc_pkg::SAMPLE_W
) (
    input wire logic ref_clk, // 50 MHz clock
    input wire logic reset, // async reset, high
    input wire logic [7:0] addr, // register byte address
    input wire logic [31:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [31:0] rdata, // read data, cycle after rd
    input wire logic [azc_pkg::LEVEL_W-1:0] rx_level, // receive FIFO count
    input wire logic left_valid, // left sample strobe
    input wire logic [SAMPLE_W-1:0] left_data, // left sample
    input wire logic right_valid, // right sample strobe
    input wire logic [SAMPLE_W-1:0] right_data, // right sample
    output logic irq // level interrupt
);
    // =========================================================
    // carriers
    azc_pkg::azc_bus_req_t req;
    azc_pkg::azc_sample_t left_s, right_s;
    logic lcross, rcross;
    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
    assign left_s = '{valid: left_valid, data: left_data};
    assign right_s = '{valid: right_valid, data: right_data};

    // =========================================================
    // crossing detectors
    azc_zc_det #(.W(SAMPLE_W)) u_left ( // RULE2
        .ref_clk(ref_clk),
        .reset(reset),
        .smp_valid(left_s.valid),
        .smp_data(left_s.data),
        .zc_pulse(lcross)
    );
    azc_zc_det #(.W(SAMPLE_W)) u_right ( // RULE6
        .ref_clk(ref_clk),
        .reset(reset),
        .smp_valid(right_s.valid),
        .smp_data(right_s.data),
        .zc_pulse(rcross)
    );

    // =========================================================
    // flags and interrupt state
    logic lflag_q, lflag_d, rflag_q, rflag_d;
    logic [1:0] ist_q, ist_d, ien_q, ien_d;
    logic [31:0] rdata_q, rdata_d;
    logic st_wr, clr_wr;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    assign st_wr = req.wr && hit(req.addr, azc_pkg::STATUS_ADDR);
    assign clr_wr = req.wr && hit(req.addr, azc_pkg::INT_CLR_ADDR);

    // sticky flags: a set in the clearing cycle wins so no crossing is lost
    always_comb
    begin
        lflag_d = lflag_q;
        rflag_d = rflag_q;
        if (st_wr && req.wdata[azc_pkg::LZC_BIT])
            lflag_d = 1'b0; // RULE3
        if (st_wr && req.wdata[azc_pkg::RZC_BIT])
            rflag_d = 1'b0; // RULE5
        if (lcross)
            lflag_d = 1'b1; // RULE3
        if (rcross)
            rflag_d = 1'b1; // RULE4
        ien_d = ien_q;
        if (req.wr && hit(req.addr, azc_pkg::INT_EN_ADDR))
            ien_d = req.wdata[azc_pkg::IRQ_R:azc_pkg::IRQ_L];
        ist_d = ist_q & ~(clr_wr ? req.wdata[azc_pkg::IRQ_R:azc_pkg::IRQ_L] : 2'h0);
        ist_d[azc_pkg::IRQ_L] = ist_d[azc_pkg::IRQ_L] | lcross;
        ist_d[azc_pkg::IRQ_R] = ist_d[azc_pkg::IRQ_R] | rcross;
    end

    // read mux; unmapped and write-only addresses read as zero
    always_comb
    begin
        rdata_d = azc_pkg::ZERO_WORD;
        if (req.rd)
        begin
            case (req.addr)
                azc_pkg::STATUS_ADDR:
                begin
                    rdata_d[azc_pkg::RX_LEVEL_MSB:azc_pkg::RX_LEVEL_LSB] = rx_level; // RULE1
                    rdata_d[azc_pkg::LZC_BIT] = lflag_q; // RULE3
                    rdata_d[azc_pkg::RZC_BIT] = rflag_q; // RULE4
                end
                azc_pkg::INT_EN_ADDR: rdata_d[azc_pkg::IRQ_R:azc_pkg::IRQ_L] = ien_q;
                azc_pkg::INT_STAT_ADDR: rdata_d[azc_pkg::IRQ_R:azc_pkg::IRQ_L] = ist_q;
                default: rdata_d = azc_pkg::ZERO_WORD;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            lflag_q <= 1'b0;
            rflag_q <= 1'b0;
            ist_q <= 2'h0;
            ien_q <= 2'h0;
            rdata_q <= azc_pkg::ZERO_WORD;
        end
        else
        begin
            lflag_q <= lflag_d;
            rflag_q <= rflag_d;
            ist_q <= ist_d;
            ien_q <= ien_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;
    assign irq = |(ist_q & ien_q);

    // =========================================================
    // checks
    property p_level_read; // RULE1
        @(posedge ref_clk) disable iff (reset)
        (rd && addr == azc_pkg::STATUS_ADDR)
            |=> rdata[azc_pkg::RX_LEVEL_MSB:azc_pkg::RX_LEVEL_LSB] == $past(rx_level);
    endproperty
    a_level_read: assert property (p_level_read) else $error("level field wrong"); // RULE1

    property p_level_range; // RULE1
        @(posedge ref_clk) disable iff (reset)
        rd |=> rdata[azc_pkg::RX_LEVEL_MSB:azc_pkg::RX_LEVEL_LSB] <= azc_pkg::LEVEL_MAX
            || $past(rx_level) > azc_pkg::LEVEL_MAX;
    endproperty
    a_level_range: assert property (p_level_range) else $error("level out of range"); // RULE1

    property p_left_zero; // RULE2
        @(posedge ref_clk) disable iff (reset)
        (left_valid && left_data == '0) |=> ##1 lflag_q;
    endproperty
    a_left_zero: assert property (p_left_zero) else $error("left zero missed"); // RULE2

    property p_left_sign; // RULE2
        @(posedge ref_clk) disable iff (reset)
        (left_valid && left_data[SAMPLE_W-1] != u_left.sign_q) |=> lcross;
    endproperty
    a_left_sign: assert property (p_left_sign) else $error("left sign change missed"); // RULE2

    property p_left_hold; // RULE3
        @(posedge ref_clk) disable iff (reset)
        (lflag_q && !(st_wr && wdata[azc_pkg::LZC_BIT])) |=> lflag_q;
    endproperty
    a_left_hold: assert property (p_left_hold) else $error("left flag dropped"); // RULE3

    property p_right_set; // RULE4
        @(posedge ref_clk) disable iff (reset)
        rcross |=> rflag_q;
    endproperty
    a_right_set: assert property (p_right_set) else $error("right flag not set"); // RULE4

    property p_right_clr; // RULE5
        @(posedge ref_clk) disable iff (reset)
        (st_wr && wdata[azc_pkg::RZC_BIT] && !rcross) |=> !rflag_q;
    endproperty
    a_right_clr: assert property (p_right_clr) else $error("right flag not cleared"); // RULE5

    property p_right_keep; // RULE5
        @(posedge ref_clk) disable iff (reset)
        (rflag_q && !(st_wr && wdata[azc_pkg::RZC_BIT])) |=> rflag_q;
    endproperty
    a_right_keep: assert property (p_right_keep) else $error("right flag lost"); // RULE5

    property p_right_zero; // RULE6
        @(posedge ref_clk) disable iff (reset)
        (right_valid && right_data == '0) |=> ##1 rflag_q;
    endproperty
    a_right_zero: assert property (p_right_zero) else $error("right zero missed"); // RULE6

    // left flag: set by the detector, dropped only by a write of 1
    property p_left_set; // RULE3
        @(posedge ref_clk) disable iff (reset)
        lcross |=> lflag_q;
    endproperty
    a_left_set: assert property (p_left_set) else $error("left flag not set"); // RULE3

    property p_left_clr; // RULE3
        @(posedge ref_clk) disable iff (reset)
        (st_wr && wdata[azc_pkg::LZC_BIT] && !lcross) |=> !lflag_q;
    endproperty
    a_left_clr: assert property (p_left_clr) else $error("left flag not cleared"); // RULE3

    // a flag never rises without a crossing behind it
    property p_left_rest; // RULE3
        @(posedge ref_clk) disable iff (reset)
        (!lflag_q && !lcross) |=> !lflag_q;
    endproperty
    a_left_rest: assert property (p_left_rest) else $error("left flag set unprompted"); // RULE3

    property p_right_rest; // RULE4
        @(posedge ref_clk) disable iff (reset)
        (!rflag_q && !rcross) |=> !rflag_q;
    endproperty
    a_right_rest: assert property (p_right_rest) else $error("right flag set unprompted"); // RULE4

    property p_right_sign; // RULE6
        @(posedge ref_clk) disable iff (reset)
        (right_valid && right_data[SAMPLE_W-1] != u_right.sign_q) |=> rcross;
    endproperty
    a_right_sign: assert property (p_right_sign) else $error("right sign change missed"); // RULE6

    // the level field only shows up in the status word
    property p_level_other; // RULE1
        @(posedge ref_clk) disable iff (reset)
        (rd && addr != azc_pkg::STATUS_ADDR)
            |=> rdata[azc_pkg::RX_LEVEL_MSB:azc_pkg::RX_LEVEL_LSB] == '0;
    endproperty
    a_level_other: assert property (p_level_other) else $error("level leaked"); // RULE1
endmodule

//--- azc_codec_model.sv
`timescale 1ns/1ps
// =========================================================
// codec side: hands over one sample word per strobe
module azc_codec_model (
    input wire logic ref_clk, // clock
    output logic left_valid, // left strobe
    output logic [azc_pkg::SAMPLE_W-1:0] left_data, // left word
    output logic right_valid, // right strobe
    output logic [azc_pkg::SAMPLE_W-1:0] right_data // right word
);
    initial
    begin
        left_valid = 1'b0;
        right_valid = 1'b0;
        left_data = 16'hFFFF;
        right_data = 16'hFFFF;
    end

    // idle lines carry the inverse word so a stale value never reads as fresh
    task automatic send(input logic ch, input logic [azc_pkg::SAMPLE_W-1:0] d);
        @(posedge ref_clk);
        if (ch) {right_valid, right_data} <= {1'b1, d};
        else {left_valid, left_data} <= {1'b1, d};
        @(posedge ref_clk);
        left_valid <= 1'b0;
        right_valid <= 1'b0;
        if (ch) right_data <= ~d;
        else left_data <= ~d;
    endtask
endmodule

//--- azc_status_test.sv
`timescale 1ns/1ps
// =========================================================
// bench: status reads, crossing flags, interrupt
module azc_status_test;
    logic ref_clk, reset, wr, rd, left_valid, right_valid, irq;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic [3:0] rx_level;
    logic [15:0] left_data, right_data;
    int err_count = 0;
    int num_checks = 0;

    azc_status u_azc_status (.ref_clk(ref_clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .rx_level(rx_level), .left_valid(left_valid),
        .left_data(left_data), .right_valid(right_valid), .right_data(right_data), .irq(irq));
    azc_codec_model u_azc_codec_model (.ref_clk(ref_clk), .left_valid(left_valid),
        .left_data(left_data), .right_valid(right_valid), .right_data(right_data));

    // =========================================================
    // bus tasks and comparison
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            $display("Error %s expected %h seen %h", n, e, s);
            err_count++;
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe, so sample just after that edge
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        {rd, addr} <= {1'b1, a};
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic smp(input logic ch, input logic [15:0] v, output logic [31:0] s);
        u_azc_codec_model.send(ch, v);
        repeat (2) @(posedge ref_clk);
        rd_reg(azc_pkg::STATUS_ADDR, s);
    endtask

    // =========================================================
    // scenarios
    task automatic level_test();
        logic [31:0] d;
        for (int i = 0; i <= 8; i++)
        begin
            @(posedge ref_clk);
            rx_level <= i[3:0];
            rd_reg(azc_pkg::STATUS_ADDR, d);
            check("rx_level", 32'(d[27:24]), i);
        end
        rd_reg(8'h04, d);
        check("unmapped", d, 32'h0000_0000);
    endtask

    // sequence isolates the all-zero test from the sign test
    task automatic chan_test(input logic ch);
        int b;
        logic [31:0] d;
        b = ch ? azc_pkg::RZC_BIT : azc_pkg::LZC_BIT;
        smp(ch, 16'h0100, d);
        check("same sign", (d >> b) & 32'h1, 32'h0);
        smp(ch, 16'h0000, d);
        check("zero word", (d >> b) & 32'h1, 32'h1);
        wr_reg(azc_pkg::STATUS_ADDR, 32'h0000_0000);
        rd_reg(azc_pkg::STATUS_ADDR, d);
        check("write 0 keeps", (d >> b) & 32'h1, 32'h1);
        wr_reg(azc_pkg::STATUS_ADDR, 32'h1 << b);
        rd_reg(azc_pkg::STATUS_ADDR, d);
        check("write 1 clears", (d >> b) & 32'h1, 32'h0);
        smp(ch, 16'h8000, d);
        check("sign change", (d >> b) & 32'h1, 32'h1);
        wr_reg(azc_pkg::STATUS_ADDR, 32'h1 << b);
        smp(ch, 16'h8001, d);
        check("negative again", (d >> b) & 32'h1, 32'h0);
    endtask

    task automatic irq_test();
        logic [31:0] d;
        // both channels crossed earlier, so start from a known clear state
        rd_reg(azc_pkg::INT_STAT_ADDR, d);
        check("int status both", d, 32'h0000_0003);
        wr_reg(azc_pkg::INT_CLR_ADDR, 32'h0000_0003);
        rd_reg(azc_pkg::INT_STAT_ADDR, d);
        check("int status clear", d, 32'h0000_0000);
        wr_reg(azc_pkg::INT_EN_ADDR, 32'h0000_0002);
        smp(1'b0, 16'h0000, d);
        check("masked irq", 32'(irq), 32'h0);
        rd_reg(azc_pkg::INT_STAT_ADDR, d);
        check("int status", d, 32'h0000_0001);
        wr_reg(azc_pkg::INT_EN_ADDR, 32'h0000_0003);
        #1 check("irq high", 32'(irq), 32'h1);
        wr_reg(azc_pkg::INT_CLR_ADDR, 32'h0000_0001);
        #1 check("irq cleared", 32'(irq), 32'h0);
    endtask

    // =========================================================
    // verdict, clock, watchdog, main sequence
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // whole run is about 120 cycles
    initial
    begin
        #200us;
        err_count++;
        complete_run();
    end

    initial
    begin
        {reset, wr, rd, addr, wdata, rx_level} = {1'b1, 2'b00, 8'h00, 32'h0, 4'h0};
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        level_test();
        chan_test(1'b0);
        chan_test(1'b1);
        irq_test();
        complete_run();
    end
endmodule
